// File: hdl/acrs_map.vh
// constants for the conversion and serial readout sequencer
`ifndef ACRS_MAP_VH
`define ACRS_MAP_VH

// output word layout
`define ACRS_WORD_W        32
`define ACRS_BIT_DONE_N    31
`define ACRS_BIT_CHAN      30
`define ACRS_BIT_RSVD      29
`define ACRS_BIT_SIGN      28
`define ACRS_DATA_LSB      4
`define ACRS_DATA_W        24
`define ACRS_PAD_W         4

// serial burst length, falling edges per word
`define ACRS_BURST_LEN     6'h20
`define ACRS_BURST_LAST    6'h1F

// cycles allowed for the sck synchroniser to fill before the mode sample
`define ACRS_SETTLE_CYC    3'h4

// result buffer shape
`define ACRS_FIFO_DEPTH    8
`define ACRS_FIFO_AW       3

// channel codes
`define ACRS_CHAN_ZERO     1'b0
`define ACRS_CHAN_ONE      1'b1

`endif

// File: hdl/acrs_sequencer.v
// conversion sequencer with result buffer and serial readout shifter
`timescale 1ns/1ps
`default_nettype none
`include "acrs_map.vh"

////////////////////////////////////////////////////////////////////////////////
// result buffer
module acrs_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output reg              in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire            do_push;
  wire            do_pop;
  reg  [AW:0]     next_count;

  assign do_push     = in_valid_i & in_ready_o;
  assign do_pop      = out_valid_o & out_ready_i;
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];

  always @* begin
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = count + {{AW{1'b0}}, 1'b1};
    end else if (do_pop && !do_push) begin
      next_count = count - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // ready is registered so the converter side sees a clean level
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr     <= {AW{1'b0}};
      rd_ptr     <= {AW{1'b0}};
      count      <= {(AW+1){1'b0}};
      in_ready_o <= 1'b1;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      count      <= next_count;
      in_ready_o <= (next_count != DEPTH[AW:0]);
    end
  end

endmodule // acrs_fifo

////////////////////////////////////////////////////////////////////////////////
// top: mode strap, channel ping-pong, sleep and serial shift-out
// Function
// - sample the serial clock line once after activation to choose clock mode
// - low at that sample selects external serial clock mode, host clock only
// - after each conversion sleep and hold the result until clocks arrive
// - shift held result out on serial data, then start the next conversion
// - converted input alternates channel zero, channel one, channel zero...
// - first conversion after power-up is on channel zero, then alternate
// - bit 30 of output word is low for channel zero, high for one
module acrs_sequencer (
  input  wire                      clk_i,
  input  wire                      rst_i,
  input  wire                      sck_i,
  output reg                       sdo_o,
  output reg                       conv_start_o,
  output reg                       conv_chan_o,
  input  wire                      conv_valid_i,
  input  wire [`ACRS_DATA_W-1:0]   conv_data_i,
  output wire                      conv_ready_o,
  output reg                       mode_ext_o,
  output reg                       sleep_o
);

  localparam [2:0] S_INIT  = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_WAIT  = 3'h2;
  localparam [2:0] S_SLEEP = 3'h3;
  localparam [2:0] S_IDLE  = 3'h4;

  reg  [2:0]              state;
  reg                     sck_meta;
  reg                     sck_sync;
  reg                     sck_prev;
  reg  [2:0]              settle;
  reg                     chan;
  reg  [5:0]              bit_cnt;
  reg  [`ACRS_WORD_W-1:0] shift;

  wire                    sck_fall;
  wire                    res_valid;
  wire [`ACRS_DATA_W-1:0] res_data;
  wire                    res_pop;
  wire [`ACRS_WORD_W-1:0] res_word;

  //////////////////////////////////////////////////////////////////////////////
  // sck synchroniser, 160 ns link clock is slow enough for edge detection
  always @(posedge clk_i) begin
    if (rst_i) begin
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      sck_meta <= sck_i;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
    end
  end

  assign sck_fall = sck_prev & ~sck_sync;

  //////////////////////////////////////////////////////////////////////////////
  // result buffer; up to eight results can be pending, and the core is stalled
  // by its ready if the readout side falls behind
  acrs_fifo #(
    .WIDTH (`ACRS_DATA_W),
    .DEPTH (`ACRS_FIFO_DEPTH),
    .AW    (`ACRS_FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (conv_valid_i),
    .in_ready_o  (conv_ready_o),
    .in_data_i   (conv_data_i),
    .out_valid_o (res_valid),
    .out_ready_i (res_pop),
    .out_data_o  (res_data)
  );

  assign res_pop = (state == S_WAIT) & res_valid;

  // done flag low, channel flag, reserved, sign, upper 20 data bits, pad, lower 4 data bits
  assign res_word = {1'b0, chan, 1'b0, 1'b0,
                     res_data[`ACRS_DATA_W-1:`ACRS_PAD_W],
                     {`ACRS_PAD_W{1'b0}},
                     res_data[`ACRS_PAD_W-1:0]};

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state        <= S_INIT;
      settle       <= 3'h0;
      chan         <= `ACRS_CHAN_ZERO;
      bit_cnt      <= 6'h00;
      shift        <= {`ACRS_WORD_W{1'b0}};
      sdo_o        <= 1'b1;
      conv_start_o <= 1'b0;
      conv_chan_o  <= `ACRS_CHAN_ZERO;
      mode_ext_o   <= 1'b0;
      sleep_o      <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      case (state)
        S_INIT: begin
          // mode is strapped once; later sck activity never changes it
          if (settle == `ACRS_SETTLE_CYC) begin
            mode_ext_o <= ~sck_sync;
            if (!sck_sync) begin
              state <= S_START;
            end else begin
              state <= S_IDLE;
            end
          end else begin
            settle <= settle + 3'h1;
          end
        end
        S_START: begin
          conv_start_o <= 1'b1;
          conv_chan_o  <= chan;
          state        <= S_WAIT;
        end
        S_WAIT: begin
          if (res_valid) begin
            shift   <= res_word;
            sdo_o   <= res_word[`ACRS_WORD_W-1];
            bit_cnt <= 6'h00;
            sleep_o <= 1'b1;
            state   <= S_SLEEP;
          end
        end
        S_SLEEP: begin
          // host samples on the rising edge, next bit appears on the falling
          if (sck_fall) begin
            shift   <= {shift[`ACRS_WORD_W-2:0], 1'b0};
            sdo_o   <= shift[`ACRS_WORD_W-2];
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == `ACRS_BURST_LAST) begin
              sleep_o <= 1'b0;
              sdo_o   <= 1'b1;
              chan    <= ~chan;
              state   <= S_START;
            end
          end
        end
        S_IDLE: begin
          // internal oscillator mode is not served by this block
          sleep_o <= 1'b0;
        end
        default: begin
          state <= S_INIT;
        end
      endcase
    end
  end

endmodule // acrs_sequencer

`default_nettype wire

// File: sim/acrs_seq_props.sv
// assertion checker for the sequencer top ports
`timescale 1ns/1ps
`default_nettype none
module acrs_seq_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic sdo_o,
  input wire logic conv_start_o,
  input wire logic conv_chan_o,
  input wire logic mode_ext_o,
  input wire logic sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_burst_end;
    $fell(sleep_o);
  endsequence
  sequence s_high_run;
    (sleep_o && sck_i) [*4];
  endsequence
  a_mode_once: assert property (mode_ext_o |=> mode_ext_o)
    else $error("mode flag dropped");
  a_int_idle: assert property (!mode_ext_o |-> !conv_start_o)
    else $error("start without external mode");
  a_first_conv: assert property ($rose(mode_ext_o) |=> conv_start_o && !conv_chan_o)
    else $error("first start wrong");
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start too long");
  a_held_word: assert property (s_high_run |=> sleep_o && $stable(sdo_o))
    else $error("result not held");
  a_done_low: assert property ($rose(sleep_o) |-> !sdo_o)
    else $error("first bit not low");
  a_next_conv: assert property (s_burst_end |=> conv_start_o && conv_chan_o != $past(conv_chan_o, 2))
    else $error("no alternate start");
  a_shift_fall: assert property (sleep_o && $past(sleep_o) && $changed(sdo_o) |-> !$past(sck_i, 2))
    else $error("bit moved off falling edge");
endmodule // acrs_seq_props
bind acrs_sequencer acrs_seq_props u_props (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i),
  .sdo_o(sdo_o), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
  .mode_ext_o(mode_ext_o), .sleep_o(sleep_o));
`default_nettype wire

// File: sim/acrs_host.sv
// host model: holds the clock line low, sends 32 pulse bursts
`timescale 1ns/1ps
`default_nettype none
module acrs_host (
  output logic      sck_o,
  input  wire logic sdo_i
);
  // low at power-up is the pull-down strap for external clock mode
  initial sck_o = 1'b0;
  // strap level for a later reset; only called while no burst runs
  task automatic strap(input logic lvl);
    sck_o <= lvl;
  endtask
  // clock stands still between bursts, samples on the rising edge
  task automatic burst(output logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      #80 sck_o <= 1'b1;
      #1 w = {w[30:0], sdo_i};
      #79 sck_o <= 1'b0;
    end
  endtask
endmodule // acrs_host
`default_nettype wire

// File: sim/tb.sv
// testbench for the conversion and serial readout sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
  logic        clk = 1'b0, rst = 1'b1, valid = 1'b0;
  logic        sdo, start, chan, ready, mode, sleep;
  logic [23:0] data = 24'h000000;
  logic [31:0] w;
  wire         sck;
  int          err_total = 0, compares = 0;
  always #2.5 clk = ~clk;
  acrs_host host_u (.sck_o(sck), .sdo_i(sdo));
  acrs_sequencer dut_u (.clk_i(clk), .rst_i(rst), .sck_i(sck), .sdo_o(sdo),
    .conv_start_o(start), .conv_chan_o(chan), .conv_valid_i(valid), .conv_data_i(data),
    .conv_ready_o(ready), .mode_ext_o(mode), .sleep_o(sleep));
  function automatic logic [31:0] ex(input logic c, input logic [23:0] d);
    return {1'b0, c, 2'b00, d[23:4], 4'h0, d[3:0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic push(input logic [23:0] d);
    @(posedge clk) valid <= 1'b1;
    data <= d;
    #1 for (int i = 0; i < 50 && ready !== 1'b1; i++) begin @(posedge clk); #1; end
    @(posedge clk) valid <= 1'b0;
  endtask
  // looks just after each edge, so the one-cycle start pulse is settled
  task automatic wait_start;
    for (int i = 0; i < 50 && start !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("start", 1'b1, start)
  endtask
  task automatic t_strap;
    #1 `CHK("sdo idle", 1'b1, sdo)
    `CHK("ready idle", 1'b1, ready)
    `CHK("sleep idle", 1'b0, sleep)
    wait_start;
    `CHK("mode", 1'b1, mode)
    `CHK("first chan", 1'b0, chan)
    $display("t_strap done");
  endtask
  task automatic t_cycle;
    logic [23:0] d;
    for (int k = 0; k < 3; k++) begin
      d = 24'hA5C3F0 + 24'(k * 24'h111111);
      if (k != 0) wait_start;
      `CHK("chan", 1'(k), chan)
      push(d);
      repeat (200) @(posedge clk);
      #1 `CHK("sleep", 1'b1, sleep)
      host_u.burst(w);
      `CHK("word", ex(1'(k), d), w)
    end
    $display("t_cycle done");
  endtask
  task automatic t_fill;
    wait_start;
    for (int k = 0; k < 9; k++) push(24'h0F0F00 + 24'(k));
    #1 `CHK("ready", 1'b0, ready)
    for (int k = 0; k < 9; k++) begin
      host_u.burst(w);
      `CHK("fill word", ex(~1'(k), 24'h0F0F00 + 24'(k)), w)
    end
    $display("t_fill done");
  endtask
  // high strap must leave the block idle; a low strap and reset restart on channel zero
  task automatic t_int_mode;
    int seen;
    seen = 0;
    repeat (10) @(posedge clk);
    host_u.strap(1'b1);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1 if (start !== 1'b0) seen++;
    end
    `CHK("int mode", 1'b0, mode)
    `CHK("int start", 0, seen)
    `CHK("int sleep", 1'b0, sleep)
    `CHK("int sdo", 1'b1, sdo)
    host_u.strap(1'b0);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_start;
    `CHK("restart mode", 1'b1, mode)
    `CHK("restart chan", 1'b0, chan)
    $display("t_int_mode done");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_strap;
    t_cycle;
    t_fill;
    t_int_mode;
    final_report;
  end
  // about 12 bursts of 5.12 us each, with margin
  initial begin
    #150000;
    err_total++;
    final_report;
  end
endmodule // tb
`default_nettype wire
